// [dv/magnetometer_threshold_output_test.sv]
// testbench: self-checking scenarios for the magnetometer threshold block
`timescale 1ns/1ps
`default_nettype none

module magnetometer_threshold_output_test;
	import mthr_pkg::*;
	logic            clk, rst, hsel, hwrite, hreadyout, hresp, strap;
	logic            dout, led_on, pwm_out, irq;
	logic [31:0]     haddr, hwdata, hrdata, rd;
	logic [1:0]      htrans;
	logic [2:0]      hsize;
	logic [6:0]      slave_addr;
	mthr_sample_type sample;
	int              miscompares = 0;
	int              n_tests = 0;

	// ****************************************
	// design and bus partner
	// ****************************************
	mthr_core dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sample(sample),
		.address_select_pin(strap), .slave_addr(slave_addr), .dout(dout),
		.led_on(led_on), .pwm_out(pwm_out), .irq(irq));
	mthr_host host_u (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	// 50 mhz clock
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			miscompares++;
		end
	endtask

	task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string what);
		host_u.xfer(1'h0, idx, 32'h0000_0000, rd);
		check(what, exp, rd);
		check("hresp", 32'h0000_0000, {31'h0, hresp});
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] val);
		host_u.xfer(1'h1, idx, val, rd);
	endtask

	// one valid pulse, then wait past the two-edge comparator latency and the irq flop
	task automatic smp(input logic [7:0] raw);
		@(posedge clk);
		sample <= {1'h1, raw, 8'h19};
		@(posedge clk);
		sample.valid <= 1'h0;
		repeat (4) @(posedge clk);
		#1;
	endtask

	task automatic outs(input logic led, input logic dv);
		check("led_on", {31'h0, led}, {31'h0, led_on});
		check("dout", {31'h0, dv}, {31'h0, dout});
	endtask

	task automatic reset_dut;
		rst <= 1'h1;
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		repeat (2) @(posedge clk);
		#1;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		check("slave_addr", 32'h0000_0048, {25'h0, slave_addr});
		rd_chk(IDX_TRIP_LOW, 32'h0000_0064, "trip_low");
		rd_chk(IDX_TRIP_HIGH, 32'h0000_0064, "trip_high");
		rd_chk(IDX_TRIP_TRIP_HYSTERESIS, 32'h0000_000A, "trip_hysteresis");
		rd_chk(IDX_INVERT, 32'h0000_0000, "invert");
		rd_chk(IDX_MODE, 32'h0000_0000, "mode");
		wr(IDX_READING, 32'h0000_0055);
		wr(8'h10, 32'h0000_00FF);
		rd_chk(IDX_READING, 32'h0000_0000, "read-only reading");
		rd_chk(8'h10, 32'h0000_0000, "unmapped");
		outs(1'h0, 1'h0);
	endtask

	task automatic t_simple;
		wr(IDX_TRIP_LOW, 32'h0000_0032);
		wr(IDX_TRIP_TRIP_HYSTERESIS, 32'h0000_0005);
		smp(8'h32);
		outs(1'h0, 1'h0);
		smp(8'hCD);
		outs(1'h1, 1'h1);
		rd_chk(IDX_READING, 32'h0000_0033, "magnitude");
		rd_chk(IDX_DOUT, 32'h0000_0001, "dout register");
		rd_chk(IDX_TEMP, 32'h0000_0019, "temperature");
		smp(8'h2E);
		outs(1'h1, 1'h1);
		smp(8'h2D);
		outs(1'h0, 1'h0);
	endtask

	task automatic t_window;
		wr(IDX_TRIP_HIGH, 32'h0000_0050);
		wr(IDX_MODE, 32'h0000_0001);
		smp(8'h4F);
		outs(1'h1, 1'h1);
		smp(8'h50);
		outs(1'h0, 1'h0);
		wr(IDX_MODE, 32'h0000_0000);
		smp(8'h50);
		outs(1'h1, 1'h1);
		smp(8'h00);
		outs(1'h0, 1'h0);
	endtask

	task automatic t_invert;
		wr(IDX_INVERT, 32'h0000_0001);
		repeat (2) @(posedge clk);
		#1;
		outs(1'h0, 1'h1);
		smp(8'h40);
		outs(1'h1, 1'h0);
		wr(IDX_INVERT, 32'h0000_0000);
		smp(8'h00);
		outs(1'h0, 1'h0);
	endtask

	task automatic t_offset;
		wr(IDX_OFFSET, 32'h0000_000A);
		smp(8'h0A);
		rd_chk(IDX_READING, 32'h0000_0000, "nulled");
		rd_chk(IDX_UNCAL, 32'h0000_000A, "uncal");
		wr(IDX_GAIN, 32'h0000_0032);
		smp(8'h4A);
		rd_chk(IDX_READING, 32'h0000_0020, "compensated");
		rd_chk(IDX_UNCAL, 32'h0000_004A, "uncal");
		wr(IDX_OFFSET, 32'h0000_0000);
		wr(IDX_GAIN, 32'h0000_0064);
		// averaging filter: half way from the previous 0x20 to the new 0x40
		wr(IDX_FILTER, 32'h0000_0002);
		smp(8'h40);
		rd_chk(IDX_READING, 32'h0000_0030, "filtered");
		wr(IDX_FILTER, 32'h0000_0001);
	endtask

	// duty counted over one whole period once the new duty has been loaded
	task automatic t_pwm;
		int cnt;
		cnt = 0;
		smp(8'h4B);
		repeat (300) @(posedge clk);
		repeat (256) begin
			@(posedge clk);
			cnt += (pwm_out === 1'h1);
		end
		check("pwm duty", (32'd75 * 32'd255) / 32'd150, cnt);
		smp(8'h00);
	endtask

	task automatic t_irq;
		wr(IDX_IRQ_CLR, 32'h0000_0007);
		wr(IDX_IRQ_EN, 32'h0000_0001);
		#1;
		check("irq idle", 32'h0000_0000, {31'h0, irq});
		smp(8'h40);
		check("irq raised", 32'h0000_0001, {31'h0, irq});
		rd_chk(IDX_IRQ_STAT, 32'h0000_0001, "irq status");
		rd_chk(IDX_IRQ_CLR, 32'h0000_0000, "irq clear reads");
		wr(IDX_IRQ_CLR, 32'h0000_0001);
		repeat (2) @(posedge clk);
		#1;
		check("irq cleared", 32'h0000_0000, {31'h0, irq});
		wr(IDX_IRQ_EN, 32'h0000_0000);
		smp(8'h00);
		smp(8'h40);
		check("irq masked", 32'h0000_0000, {31'h0, irq});
		rd_chk(IDX_IRQ_STAT, 32'h0000_0003, "irq status");
		// reading beyond the linear range raises the range bit
		smp(8'h70);
		rd_chk(IDX_IRQ_STAT, 32'h0000_0007, "irq range");
	endtask

	task automatic t_strap;
		strap <= 1'h0;
		reset_dut();
		check("slave_addr", 32'h0000_0010, {25'h0, slave_addr});
		rd_chk(IDX_I2C_ADDR, 32'h0000_0010, "i2c addr");
	endtask

	// ****************************************
	// run control
	// ****************************************
	task automatic end_of_test;
		$display("compares %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// watchdog well beyond the roughly 800 cycles the run needs
	initial begin
		#400000;
		miscompares++;
		end_of_test();
	end

	// main sequence
	initial begin
		rst = 1'h1;
		strap = 1'h1;
		sample = '0;
		reset_dut();
		t_reset();
		t_simple();
		t_window();
		t_invert();
		t_offset();
		t_pwm();
		t_irq();
		t_strap();
		end_of_test();
	end
endmodule // magnetometer_threshold_output_test

`default_nettype wire

// [dv/mthr_host.sv]
// partner model: ahb-lite master standing in for the reading microcontroller
`timescale 1ns/1ps
`default_nettype none

module mthr_host
	import mthr_pkg::*;
(
	// clock and bus answer
	input  wire logic        clk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	// bus request
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	// idle bus from time zero, so reset never sees a request
	initial begin
		hsel   = 1'h0;
		haddr  = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize  = 3'h2;
		hwdata = 32'h0000_0000;
	end

	// one whole-word transfer; no cycle count assumed, only the bench timeout ends a wait
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk);
		hsel   <= 1'h1;
		haddr  <= {22'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize  <= 3'h2;
		do @(posedge clk); while (hready !== 1'h1);
		hsel   <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'h1);
		rd = hrdata;
	endtask
endmodule // mthr_host

`default_nettype wire

// [src/mthr_core.sv]
// file: register file, field processing, comparator, pwm and interrupt of the magnetometer block
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module mthr_core
	import mthr_pkg::*;
(
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// ahb-lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic [31:0]                hrdata,
	output logic                       hresp,
	// sensor front end
	input  wire mthr_pkg::mthr_sample_type sample,
	input  wire logic                  address_select_pin,
	// outputs
	output logic [6:0]                 slave_addr,
	output logic                       dout,
	output logic                       led_on,
	output logic                       pwm_out,
	output logic                       irq
);
	import mthr_pkg::*;

	// ****************************************
	// helper functions
	// ****************************************
	function automatic logic [7:0] sat8(input logic [16:0] v);
		sat8 = (v > 17'h0_00FF) ? 8'hFF : v[7:0];
	endfunction

	function automatic logic [8:0] abs9(input logic signed [8:0] v);
		abs9 = v[8] ? 9'(-v) : 9'(v);
	endfunction

	// ****************************************
	// state
	// ****************************************
	mthr_cfg_type     cfg_reg;
	logic [7:0]       reading_reg;
	logic [7:0]       uncal_reg;
	logic [7:0]       temp_reg;
	logic             eval_reg;
	logic             active_reg;
	logic             active_next;
	logic             strap_done_reg;
	logic [7:0]       pwm_cnt_reg;
	logic [7:0]       pwm_duty_reg;
	logic [IRQ_W-1:0] irq_stat_reg;
	logic [IRQ_W-1:0] irq_en_reg;
	logic [IRQ_W-1:0] irq_evt;
	logic             wr_pend_reg;
	logic [7:0]       wr_idx_reg;
	logic [7:0]       addr_idx;
	logic             addr_phase;

	assign addr_idx   = haddr[ADDR_LSB+7:ADDR_LSB];
	assign addr_phase = hsel && hready && htrans[1];

	// read decode, shared by the data latch below and nothing else on the read side
	function automatic logic [31:0] rd_mux(input logic [7:0] idx);
		case (idx)
			IDX_READING:   rd_mux = {24'h00_0000, reading_reg};
			IDX_UNCAL:     rd_mux = {24'h00_0000, uncal_reg};
			IDX_TEMP:      rd_mux = {24'h00_0000, temp_reg};
			IDX_DOUT:      rd_mux = {31'h0000_0000, dout};
			IDX_I2C_ADDR:  rd_mux = {25'h000_0000, slave_addr};
			IDX_TRIP_LOW:  rd_mux = {24'h00_0000, cfg_reg.trip_low};
			IDX_TRIP_HIGH: rd_mux = {24'h00_0000, cfg_reg.trip_high};
			IDX_TRIP_TRIP_HYSTERESIS: rd_mux = {24'h00_0000, cfg_reg.trip_trip_hysteresis};
			IDX_INVERT:    rd_mux = {31'h0000_0000, cfg_reg.invert};
			IDX_OFFSET:    rd_mux = {24'h00_0000, cfg_reg.offset};
			IDX_GAIN:      rd_mux = {24'h00_0000, cfg_reg.gain};
			IDX_FILTER:    rd_mux = {24'h00_0000, cfg_reg.filter_m};
			IDX_MODE:      rd_mux = {31'h0000_0000, cfg_reg.mode};
			IDX_IRQ_STAT:  rd_mux = {29'h0000_0000, irq_stat_reg};
			IDX_IRQ_EN:    rd_mux = {29'h0000_0000, irq_en_reg};
			default:       rd_mux = 32'h0000_0000;
		endcase
	endfunction

	// ****************************************
	// ahb-lite slave
	// ****************************************
	// zero wait states; read data latched in the address phase so hrdata is a flop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			hrdata      <= 32'h0000_0000;
			wr_pend_reg <= 1'b0;
			wr_idx_reg  <= 8'h00;
		end else begin
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			wr_pend_reg <= addr_phase && hwrite;
			if (addr_phase) begin
				wr_idx_reg <= addr_idx;
			end
			if (addr_phase && !hwrite) begin
				hrdata <= rd_mux(addr_idx);
			end
		end
	end

	// configuration writes land in the data phase; unmapped indices are ignored
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_reg.trip_low  <= RST_TRIP_LOW;
			cfg_reg.trip_high <= RST_TRIP_HIGH;
			cfg_reg.trip_trip_hysteresis <= RST_TRIP_TRIP_HYSTERESIS;
			cfg_reg.invert    <= 1'b0;
			cfg_reg.offset    <= RST_OFFSET;
			cfg_reg.gain      <= RST_GAIN;
			cfg_reg.filter_m  <= RST_FILTER;
			cfg_reg.mode      <= MTHR_SIMPLE;
		end else if (wr_pend_reg) begin
			case (wr_idx_reg)
				IDX_TRIP_LOW:  cfg_reg.trip_low  <= hwdata[7:0];
				IDX_TRIP_HIGH: cfg_reg.trip_high <= hwdata[7:0];
				IDX_TRIP_TRIP_HYSTERESIS: cfg_reg.trip_trip_hysteresis <= hwdata[7:0];
				IDX_INVERT:    cfg_reg.invert    <= hwdata[0];
				IDX_OFFSET:    cfg_reg.offset    <= hwdata[7:0];
				IDX_GAIN:      cfg_reg.gain      <= hwdata[7:0];
				IDX_FILTER:    cfg_reg.filter_m  <= hwdata[7:0];
				IDX_MODE:      cfg_reg.mode      <= mthr_mode_type'(hwdata[0]);
				default:       cfg_reg.mode      <= cfg_reg.mode;
			endcase
		end
	end

	// ****************************************
	// address strap
	// ****************************************
	// caught one edge after reset release; async reset may only load a constant
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strap_done_reg <= 1'b0;
			slave_addr     <= I2C_ADDR_OPEN;
		end else if (!strap_done_reg) begin
			strap_done_reg <= 1'b1;
			slave_addr     <= address_select_pin ? I2C_ADDR_OPEN : I2C_ADDR_GND;
		end
	end

	// ****************************************
	// field processing
	// ****************************************
	logic signed [8:0] corr_s;
	logic [8:0]        corr_mag;
	logic [8:0]        raw_mag;
	logic [16:0]       gained;
	logic [7:0]        cal_val;
	logic [7:0]        filt_val;

	// offset subtracted before rectifying so a background field nulls out
	always_comb begin
		corr_s   = $signed({sample.raw[7], sample.raw}) - $signed({cfg_reg.offset[7], cfg_reg.offset});
		corr_mag = abs9(corr_s);
		raw_mag  = abs9($signed({sample.raw[7], sample.raw}));
		gained   = 17'((corr_mag * cfg_reg.gain) / GAIN_UNITY);
		cal_val  = sat8(gained);
		// one-pole average; any m above one halves the step, m of one bypasses
		filt_val = (cfg_reg.filter_m > 8'h01)
			? 8'(({1'b0, reading_reg} + {1'b0, cal_val}) >> 1) : cal_val;
	end

	// readings update on the sample strobe; eval pulse follows one cycle later
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reading_reg <= 8'h00;
			uncal_reg   <= 8'h00;
			temp_reg    <= 8'h00;
			eval_reg    <= 1'b0;
		end else begin
			eval_reg <= sample.valid;
			if (sample.valid) begin
				reading_reg <= filt_val;
				uncal_reg   <= sat8({8'h00, raw_mag});
				temp_reg    <= sample.temp;
			end
		end
	end

	// ****************************************
	// comparator
	// ****************************************
	logic [7:0] release_lvl;
	logic       above_low;
	logic       at_high;

	always_comb begin
		release_lvl = (cfg_reg.trip_low > cfg_reg.trip_trip_hysteresis)
			? 8'(cfg_reg.trip_low - cfg_reg.trip_trip_hysteresis) : 8'h00;
		above_low   = reading_reg > cfg_reg.trip_low;
		at_high     = (cfg_reg.mode == MTHR_WINDOW) && (reading_reg >= cfg_reg.trip_high);
		active_next = active_reg;
		if (eval_reg) begin
			if (at_high) begin
				active_next = 1'b0;
			end else if (!active_reg && above_low) begin
				active_next = 1'b1;
			end else if (active_reg && reading_reg <= release_lvl) begin
				active_next = 1'b0;
			end
		end
	end

	// dout is recomputed every edge so a polarity write takes effect at once
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			active_reg <= 1'b0;
			led_on     <= 1'b0;
			dout       <= 1'b0;
		end else begin
			active_reg <= active_next;
			led_on     <= active_next;
			dout       <= active_next ^ cfg_reg.invert;
		end
	end

	// ****************************************
	// pwm copy of the field
	// ****************************************
	logic [15:0] duty_calc;
	assign duty_calc = 16'((reading_reg * PWM_TOP) / PWM_FULL_PCT);

	// duty reloads at the period wrap so a cycle never carries two widths
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pwm_cnt_reg  <= 8'h00;
			pwm_duty_reg <= 8'h00;
			pwm_out      <= 1'b0;
		end else begin
			pwm_cnt_reg <= 8'(pwm_cnt_reg + 8'h01);
			if (pwm_cnt_reg == 8'hFF) begin
				pwm_duty_reg <= sat8({1'b0, duty_calc});
			end
			pwm_out <= pwm_cnt_reg < pwm_duty_reg;
		end
	end

	// ****************************************
	// interrupts
	// ****************************************
	assign irq_evt[IRQ_ON]    = active_next && !active_reg;
	assign irq_evt[IRQ_OFF]   = !active_next && active_reg;
	assign irq_evt[IRQ_RANGE] = eval_reg && ({1'b0, reading_reg} > LINEAR_PCT);

	// a new event wins over a clear in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_stat_reg <= '0;
			irq_en_reg   <= '0;
			irq          <= 1'b0;
		end else begin
			if (wr_pend_reg && wr_idx_reg == IDX_IRQ_EN) begin
				irq_en_reg <= hwdata[IRQ_W-1:0];
			end
			if (wr_pend_reg && wr_idx_reg == IDX_IRQ_CLR) begin
				irq_stat_reg <= (irq_stat_reg & ~hwdata[IRQ_W-1:0]) | irq_evt;
			end else begin
				irq_stat_reg <= irq_stat_reg | irq_evt;
			end
			irq <= |(irq_stat_reg & irq_en_reg);
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_strap;
		$rose(strap_done_reg) |-> slave_addr == ($past(address_select_pin) ? I2C_ADDR_OPEN : I2C_ADDR_GND);
	endproperty
	a_strap: assert property (p_strap) else $error("slave address not set from strap");

	property p_pwm;
		(pwm_cnt_reg == 8'hFF) ##1 (pwm_cnt_reg == 8'h00) |=> pwm_out == (pwm_duty_reg != 8'h00);
	endproperty
	a_pwm: assert property (p_pwm) else $error("pwm level wrong at period start");

	property p_led_dout;
		$stable(cfg_reg.invert) |-> (dout == (led_on ^ cfg_reg.invert));
	endproperty
	a_led_dout: assert property (p_led_dout) else $error("led and dout disagree");

	property p_trip_write;
		wr_pend_reg && (wr_idx_reg == IDX_TRIP_LOW) |=> cfg_reg.trip_low == $past(hwdata[7:0]);
	endproperty
	a_trip_write: assert property (p_trip_write) else $error("low trip write lost");

	property p_trip_reset;
		$rose(strap_done_reg) |-> cfg_reg.trip_low == RST_TRIP_LOW;
	endproperty
	a_trip_reset: assert property (p_trip_reset) else $error("trip level reset value wrong");

	property p_read_reading;
		addr_phase && !hwrite && (addr_idx == IDX_READING) |=> hrdata == {24'h00_0000, $past(reading_reg)};
	endproperty
	a_read_reading: assert property (p_read_reading) else $error("reading not returned at zero");

	property p_magnitude;
		sample.valid |=> uncal_reg == ($past(sample.raw[7]) ? 8'(-$past(sample.raw)) : $past(sample.raw));
	endproperty
	a_magnitude: assert property (p_magnitude) else $error("uncompensated value not a magnitude");

	property p_turn_on;
		eval_reg && !active_reg && (cfg_reg.mode == MTHR_SIMPLE) && above_low |=> active_reg && led_on;
	endproperty
	a_turn_on: assert property (p_turn_on) else $error("output did not turn on above trip");

	property p_window_off;
		eval_reg && (cfg_reg.mode == MTHR_WINDOW) && (reading_reg >= cfg_reg.trip_high) |=> !active_reg;
	endproperty
	a_window_off: assert property (p_window_off) else $error("window upper trip ignored");

	property p_trip_hysteresis_hold;
		eval_reg && active_reg && !at_high && (reading_reg > release_lvl) |=> active_reg;
	endproperty
	a_trip_hysteresis_hold: assert property (p_trip_hysteresis_hold) else $error("released above trip minus hysteresis");

endmodule // mthr_core

`default_nettype wire

// [src/mthr_pkg.sv]
// package: memory map, reset values and carrier types of the magnetometer threshold block
package mthr_pkg;

	// ****************************************
	// memory indices (byte address = 4 * index)
	// ****************************************
	localparam logic [7:0] IDX_READING   = 8'h00;
	localparam logic [7:0] IDX_UNCAL     = 8'h01;
	localparam logic [7:0] IDX_TEMP      = 8'h02;
	localparam logic [7:0] IDX_DOUT      = 8'h03;
	localparam logic [7:0] IDX_I2C_ADDR  = 8'h04;
	localparam logic [7:0] IDX_TRIP_LOW  = 8'h20;
	localparam logic [7:0] IDX_TRIP_HIGH = 8'h21;
	localparam logic [7:0] IDX_TRIP_TRIP_HYSTERESIS = 8'h22;
	localparam logic [7:0] IDX_INVERT    = 8'h23;
	localparam logic [7:0] IDX_OFFSET    = 8'h24;
	localparam logic [7:0] IDX_GAIN      = 8'h25;
	localparam logic [7:0] IDX_FILTER    = 8'h29;
	localparam logic [7:0] IDX_MODE      = 8'h2C;
	localparam logic [7:0] IDX_IRQ_STAT  = 8'h30;
	localparam logic [7:0] IDX_IRQ_CLR   = 8'h31;
	localparam logic [7:0] IDX_IRQ_EN    = 8'h32;
	localparam int         ADDR_LSB      = 2;

	// ****************************************
	// reset values and scaling
	// ****************************************
	localparam logic [7:0] RST_TRIP_LOW  = 8'h64;
	localparam logic [7:0] RST_TRIP_HIGH = 8'h64;
	localparam logic [7:0] RST_TRIP_TRIP_HYSTERESIS = 8'h0A;
	localparam logic [7:0] RST_OFFSET    = 8'h00;
	localparam logic [7:0] RST_GAIN      = 8'h64;
	localparam logic [7:0] RST_FILTER    = 8'h01;
	localparam logic [6:0] I2C_ADDR_OPEN = 7'h48;
	localparam logic [6:0] I2C_ADDR_GND  = 7'h10;
	localparam logic [16:0] GAIN_UNITY   = 17'h0_0064;
	localparam logic [15:0] PWM_FULL_PCT = 16'h0096;
	localparam logic [15:0] PWM_TOP      = 16'h00FF;
	localparam logic [8:0]  LINEAR_PCT   = 9'h064;
	localparam int          IRQ_W        = 3;
	localparam int          IRQ_ON       = 0;
	localparam int          IRQ_OFF      = 1;
	localparam int          IRQ_RANGE    = 2;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [0:0] {
		MTHR_SIMPLE = 1'b0,
		MTHR_WINDOW = 1'b1
	} mthr_mode_type;

	typedef struct packed {
		logic [7:0]    trip_low;
		logic [7:0]    trip_high;
		logic [7:0]    trip_trip_hysteresis;
		logic          invert;
		logic [7:0]    offset;
		logic [7:0]    gain;
		logic [7:0]    filter_m;
		mthr_mode_type mode;
	} mthr_cfg_type;

	typedef struct packed {
		logic       valid;
		logic [7:0] raw;
		logic [7:0] temp;
	} mthr_sample_type;

endpackage
